// *** rtl/amp_regs_pkg.sv ***
// Register map, field positions and reset values of the amplifier
// control and status bank. Assumes an APB master with 32-bit data.
package amp_regs_pkg;

    // Printed offsets are not multiples of four: byte address = 4 * index
    localparam logic [7:0] IDX_IDENT     = 8'h01;
    localparam logic [7:0] IDX_ERR       = 8'h02;
    localparam logic [7:0] IDX_SYS_ONE   = 8'h03;
    localparam logic [7:0] IDX_SER_FMT   = 8'h04;
    localparam logic [7:0] IDX_SYS_TWO   = 8'h05;
    localparam logic [7:0] IDX_SOFT_MUTE = 8'h06;
    localparam logic [7:0] IDX_IRQ_EN    = 8'h07;
    localparam logic [7:0] IDX_IRQ_CLR   = 8'h08;

    localparam int unsigned ADDR_W = 12;

    // Identity value is arbitrary
    localparam logic [7:0] IDENT_VALUE   = 8'h00;

    // Error status bit positions
    localparam int unsigned ERR_MCLK     = 7;
    localparam int unsigned ERR_PLL      = 6;
    localparam int unsigned ERR_SCLK     = 5;
    localparam int unsigned ERR_LRCLK    = 4;
    localparam int unsigned ERR_SLIP     = 3;
    localparam int unsigned ERR_CLIP     = 2;
    localparam int unsigned ERR_FAULT    = 1;

    // System control one fields
    localparam int unsigned SC1_DCBLK    = 7;
    localparam int unsigned SC1_HARDUNM  = 5;
    localparam logic [7:0] SC1_MASK      = 8'hA3;
    localparam logic [7:0] SC1_RESET     = 8'hA0;

    // Serial format
    localparam logic [7:0] FMT_MASK      = 8'h0F;
    localparam logic [3:0] FMT_RESET     = 4'h5;
    localparam logic [3:0] FMT_LAST      = 4'h8;

    // System control two fields
    localparam int unsigned SC2_MIDZ     = 7;
    localparam int unsigned SC2_SHDN     = 6;
    localparam int unsigned SC2_FAULTOUT = 1;
    localparam logic [7:0] SC2_MASK      = 8'hC2;
    localparam logic [7:0] SC2_RESET     = 8'h40;

    localparam logic [7:0] MUTE_MASK     = 8'h07;
    localparam logic [7:0] ERR_MASK      = 8'hFE;

endpackage

// *** rtl/amp_status_control_regs.sv ***
// Control/status register bank of a class-D amplifier, APB slave.
// Assumes error event pulses are synchronous to clk_i.
`timescale 1ns/1ps

module amp_status_control_regs (
    // Clock and reset
    input  wire logic                         clk_i,
    input  wire logic                         srst_i,
    // APB slave
    input  wire logic                         psel_i,
    input  wire logic                         penable_i,
    input  wire logic                         pwrite_i,
    input  wire logic [amp_regs_pkg::ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]                  pwdata_i,
    output logic      [31:0]                  prdata_o,
    output logic                              pready_o,
    output logic                              pslverr_o,
    // Error events, one-cycle pulses
    input  wire logic                         mclk_err_i,
    input  wire logic                         pll_err_i,
    input  wire logic                         sclk_err_i,
    input  wire logic                         lrclk_err_i,
    input  wire logic                         frame_slip_i,
    input  wire logic                         clip_i,
    input  wire logic                         fault_i,
    // Control outputs
    output logic                              dc_block_en_o,
    output logic                              hard_unmute_o,
    output logic      [1:0]                   deemph_sel_o,
    output logic      [3:0]                   serial_fmt_o,
    output logic                              shutdown_o,
    output logic                              midz_ramp_en_o,
    output logic                              fault_pin_oe_n_o,
    output logic      [2:0]                   soft_mute_o,
    // Interrupt
    output logic                              irq_o
);

    logic [7:0] err_q;
    logic [7:0] sc1_q;
    logic [3:0] fmt_q;
    logic [7:0] sc2_q;
    logic [2:0] mute_q;
    logic [7:0] irq_en_q;
    logic [7:0] err_set;
    logic [7:0] err_clr;
    logic       wr_en;
    logic [9:0] idx;
    logic       mapped;

    function automatic logic hit(input logic [9:0] i,
                                 input logic [7:0] r);
        return i == {2'b00, r};
    endfunction

    assign idx     = paddr_i[amp_regs_pkg::ADDR_W-1:2];
    assign wr_en   = psel_i & penable_i & pwrite_i;
    assign pready_o = 1'b1;
    assign mapped  = (idx >= 10'h001) && (idx <= 10'h008);
    assign pslverr_o = psel_i & penable_i & ~mapped;

    // Event vector in status layout
    always_comb begin
        err_set = 8'h00;
        err_set[amp_regs_pkg::ERR_MCLK]  = mclk_err_i;
        err_set[amp_regs_pkg::ERR_PLL]   = pll_err_i;
        err_set[amp_regs_pkg::ERR_SCLK]  = sclk_err_i;
        err_set[amp_regs_pkg::ERR_LRCLK] = lrclk_err_i;
        err_set[amp_regs_pkg::ERR_SLIP]  = frame_slip_i;
        err_set[amp_regs_pkg::ERR_CLIP]  = clip_i;
        err_set[amp_regs_pkg::ERR_FAULT] = fault_i;
    end

    // Writing zeroes to status or ones to the clear register clears
    always_comb begin
        err_clr = 8'h00;
        if (wr_en && hit(idx, amp_regs_pkg::IDX_ERR)) begin
            err_clr = ~pwdata_i[7:0];
        end else if (wr_en && hit(idx, amp_regs_pkg::IDX_IRQ_CLR)) begin
            err_clr = pwdata_i[7:0];
        end
    end

    // Sticky flags; a new event wins over a clear
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            err_q <= 8'h00;
        end else begin
            err_q <= ((err_q & ~err_clr) | err_set)
                     & amp_regs_pkg::ERR_MASK;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            sc1_q <= amp_regs_pkg::SC1_RESET;
        end else if (wr_en && hit(idx, amp_regs_pkg::IDX_SYS_ONE)) begin
            sc1_q <= pwdata_i[7:0] & amp_regs_pkg::SC1_MASK;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            fmt_q <= amp_regs_pkg::FMT_RESET;
        end else if (wr_en && hit(idx, amp_regs_pkg::IDX_SER_FMT)) begin
            fmt_q <= pwdata_i[3:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            sc2_q <= amp_regs_pkg::SC2_RESET;
        end else if (wr_en && hit(idx, amp_regs_pkg::IDX_SYS_TWO)) begin
            sc2_q <= pwdata_i[7:0] & amp_regs_pkg::SC2_MASK;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            mute_q <= 3'h0;
        end else if (wr_en && hit(idx, amp_regs_pkg::IDX_SOFT_MUTE)) begin
            mute_q <= pwdata_i[2:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            irq_en_q <= 8'h00;
        end else if (wr_en && hit(idx, amp_regs_pkg::IDX_IRQ_EN)) begin
            irq_en_q <= pwdata_i[7:0] & amp_regs_pkg::ERR_MASK;
        end
    end

    // Read mux, registered
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (psel_i && !penable_i && !pwrite_i) begin
            prdata_o <= 32'h0000_0000;
            if (hit(idx, amp_regs_pkg::IDX_IDENT)) begin
                prdata_o[7:0] <= amp_regs_pkg::IDENT_VALUE;
            end else if (hit(idx, amp_regs_pkg::IDX_ERR)) begin
                prdata_o[7:0] <= err_q;
            end else if (hit(idx, amp_regs_pkg::IDX_SYS_ONE)) begin
                prdata_o[7:0] <= sc1_q;
            end else if (hit(idx, amp_regs_pkg::IDX_SER_FMT)) begin
                prdata_o[3:0] <= fmt_q;
            end else if (hit(idx, amp_regs_pkg::IDX_SYS_TWO)) begin
                prdata_o[7:0] <= sc2_q;
            end else if (hit(idx, amp_regs_pkg::IDX_SOFT_MUTE)) begin
                prdata_o[2:0] <= mute_q;
            end else if (hit(idx, amp_regs_pkg::IDX_IRQ_EN)) begin
                prdata_o[7:0] <= irq_en_q;
            end
        end
    end

    assign dc_block_en_o    = sc1_q[amp_regs_pkg::SC1_DCBLK];
    assign hard_unmute_o    = sc1_q[amp_regs_pkg::SC1_HARDUNM];
    assign deemph_sel_o     = sc1_q[1:0];
    assign serial_fmt_o     = fmt_q;
    assign shutdown_o       = sc2_q[amp_regs_pkg::SC2_SHDN];
    assign midz_ramp_en_o   = sc2_q[amp_regs_pkg::SC2_MIDZ];
    assign fault_pin_oe_n_o = ~sc2_q[amp_regs_pkg::SC2_FAULTOUT];
    assign soft_mute_o      = mute_q;
    assign irq_o            = |(err_q & irq_en_q);

    // Assertions
    sticky_err_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (err_q[7] && err_clr[7] == 1'b0) |=> err_q[7])
        else $error("error flag dropped without clear");
    mclk_set_a: assert property (@(posedge clk_i) disable iff (srst_i)
        mclk_err_i |=> err_q[amp_regs_pkg::ERR_MCLK])
        else $error("mclk event not captured");
    sclk_set_a: assert property (@(posedge clk_i) disable iff (srst_i)
        sclk_err_i |=> err_q[amp_regs_pkg::ERR_SCLK])
        else $error("sclk event not captured");
    lrclk_set_a: assert property (@(posedge clk_i) disable iff (srst_i)
        lrclk_err_i |=> err_q[amp_regs_pkg::ERR_LRCLK])
        else $error("lrclk event not captured");
    slip_set_a: assert property (@(posedge clk_i) disable iff (srst_i)
        frame_slip_i |=> err_q[amp_regs_pkg::ERR_SLIP])
        else $error("frame slip not captured");
    fault_set_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (pll_err_i && clip_i && fault_i) |=> (err_q[6:1] & 6'h23) == 6'h23)
        else $error("pll clip or fault not captured");
    ident_read_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (psel_i && !penable_i && !pwrite_i
         && hit(idx, amp_regs_pkg::IDX_IDENT))
        |=> prdata_o == {24'h0, amp_regs_pkg::IDENT_VALUE})
        else $error("identification read wrong");
    mute_write_a: assert property (@(posedge clk_i) disable iff (srst_i)
        (wr_en && hit(idx, amp_regs_pkg::IDX_SOFT_MUTE))
        |=> soft_mute_o == $past(pwdata_i[2:0]))
        else $error("soft mute write lost");
    shutdown_a: assert property (@(posedge clk_i)
        $fell(srst_i) |-> shutdown_o && hard_unmute_o && dc_block_en_o)
        else $error("control defaults wrong");
    fmt_reset_a: assert property (@(posedge clk_i)
        $fell(srst_i) |-> serial_fmt_o == 4'h5)
        else $error("format default wrong");

    // Decoded accesses watched by the checks below
    logic rd_setup;
    logic wr_err;
    logic wr_clr;
    logic wr_sc1;
    logic wr_fmt;
    logic wr_sc2;
    logic wr_mute;

    assign rd_setup = psel_i & ~penable_i & ~pwrite_i;
    assign wr_err   = wr_en & hit(idx, amp_regs_pkg::IDX_ERR);
    assign wr_clr   = wr_en & hit(idx, amp_regs_pkg::IDX_IRQ_CLR);
    assign wr_sc1   = wr_en & hit(idx, amp_regs_pkg::IDX_SYS_ONE);
    assign wr_fmt   = wr_en & hit(idx, amp_regs_pkg::IDX_SER_FMT);
    assign wr_sc2   = wr_en & hit(idx, amp_regs_pkg::IDX_SYS_TWO);
    assign wr_mute  = wr_en & hit(idx, amp_regs_pkg::IDX_SOFT_MUTE);

    // Status flags
    sticky_all_a: assert property (@(posedge clk_i)
        disable iff (srst_i)
        1'b1 |=> (err_q & $past(err_q & ~err_clr))
                 == $past(err_q & ~err_clr))
        else $error("error flag dropped by hardware");

    err_bit0_a: assert property (@(posedge clk_i)
        disable iff (srst_i)
        err_q[0] == 1'b0)
        else $error("reserved status bit set");

    pll_set_a: assert property (@(posedge clk_i)
        disable iff (srst_i)
        pll_err_i |=> err_q[amp_regs_pkg::ERR_PLL])
        else $error("pll event not captured");

    clip_set_a: assert property (@(posedge clk_i)
        disable iff (srst_i)
        clip_i |=> err_q[amp_regs_pkg::ERR_CLIP])
        else $error("clip event not captured");

    fault_only_a: assert property (@(posedge clk_i)
        disable iff (srst_i)
        fault_i |=> err_q[amp_regs_pkg::ERR_FAULT])
        else $error("power fault not captured");

    no_spurious_a: assert property (@(posedge clk_i)
        disable iff (srst_i)
        (err_set == 8'h00) |=> (err_q & ~$past(err_q)) == 8'h00)
        else $error("flag set without event");

    zero_clear_a: assert property (@(posedge clk_i)
        disable iff (srst_i)
        (wr_err && pwdata_i[7:0] == 8'h00 && err_set == 8'h00)
        |=> err_q == 8'h00)
        else $error("zero write did not clear status");

    clr_all_a: assert property (@(posedge clk_i)
        disable iff (srst_i)
        (wr_clr && pwdata_i[7:0] == 8'hFF && err_set == 8'h00)
        |=> err_q == 8'h00)
        else $error("clear register did not clear status");

    set_wins_a: assert property (@(posedge clk_i)
        disable iff (srst_i)
        (mclk_err_i && err_clr[amp_regs_pkg::ERR_MCLK])
        |=> err_q[amp_regs_pkg::ERR_MCLK])
        else $error("clear beat a new event");

    err_reset_a: assert property (@(posedge clk_i)
        $fell(srst_i) |-> err_q == 8'h00)
        else $error("status not clear after reset");

    err_read_a: assert property (@(posedge clk_i)
        disable iff (srst_i)
        (rd_setup && hit(idx, amp_regs_pkg::IDX_ERR))
        |=> prdata_o == {24'h0, $past(err_q)})
        else $error("status read wrong");

    // System control one
    dc_block_a: assert property (@(posedge clk_i)
        disable iff (srst_i)
        wr_sc1 |=> dc_block_en_o
                   == $past(pwdata_i[amp_regs_pkg::SC1_DCBLK]))
        else $error("dc blocking enable wrong");

    unmute_mode_a: assert property (@(posedge clk_i)
        disable iff (srst_i)
        wr_sc1 |=> hard_unmute_o
                   == $past(pwdata_i[amp_regs_pkg::SC1_HARDUNM]))
        else $error("unmute mode wrong");

    deemph_a: assert property (@(posedge clk_i)
        disable iff (srst_i)
        wr_sc1 |=> deemph_sel_o == $past(pwdata_i[1:0]))
        else $error("de-emphasis select wrong");

    sc1_hold_a: assert property (@(posedge clk_i)
        disable iff (srst_i)
        !wr_sc1 |=> $stable(sc1_q))
        else $error("control one changed without write");

    sc1_read_a: assert property (@(posedge clk_i)
        disable iff (srst_i)
        (rd_setup && hit(idx, amp_regs_pkg::IDX_SYS_ONE))
        |=> prdata_o == {24'h0, $past(sc1_q)})
        else $error("control one read wrong");

    deemph_reset_a: assert property (@(posedge clk_i)
        $fell(srst_i) |-> deemph_sel_o == 2'b00)
        else $error("de-emphasis default wrong");

    // Serial format
    fmt_write_a: assert property (@(posedge clk_i)
        disable iff (srst_i)
        wr_fmt |=> serial_fmt_o == $past(pwdata_i[3:0]))
        else $error("format write lost");

    fmt_hold_a: assert property (@(posedge clk_i)
        disable iff (srst_i)
        !wr_fmt |=> $stable(fmt_q))
        else $error("format changed without write");

    fmt_read_a: assert property (@(posedge clk_i)
        disable iff (srst_i)
        (rd_setup && hit(idx, amp_regs_pkg::IDX_SER_FMT))
        |=> prdata_o == {28'h0, $past(fmt_q)})
        else $error("format read wrong");

    // System control two
    shdn_write_a: assert property (@(posedge clk_i)
        disable iff (srst_i)
        wr_sc2 |=> shutdown_o
                   == $past(pwdata_i[amp_regs_pkg::SC2_SHDN]))
        else $error("shutdown write lost");

    midz_write_a: assert property (@(posedge clk_i)
        disable iff (srst_i)
        wr_sc2 |=> midz_ramp_en_o
                   == $past(pwdata_i[amp_regs_pkg::SC2_MIDZ]))
        else $error("mid-z ramp write lost");

    fault_dir_a: assert property (@(posedge clk_i)
        disable iff (srst_i)
        wr_sc2 |=> fault_pin_oe_n_o
                   == !$past(pwdata_i[amp_regs_pkg::SC2_FAULTOUT]))
        else $error("fault pin direction wrong");

    sc2_hold_a: assert property (@(posedge clk_i)
        disable iff (srst_i)
        !wr_sc2 |=> $stable(sc2_q))
        else $error("control two changed without write");

    dir_reset_a: assert property (@(posedge clk_i)
        $fell(srst_i) |-> fault_pin_oe_n_o && !midz_ramp_en_o)
        else $error("control two default wrong");

    // Soft mute
    mute_release_a: assert property (@(posedge clk_i)
        disable iff (srst_i)
        (wr_mute && !pwdata_i[0]) |=> !soft_mute_o[0])
        else $error("channel not released from mute");

    mute_hold_a: assert property (@(posedge clk_i)
        disable iff (srst_i)
        !wr_mute |=> $stable(mute_q))
        else $error("mute changed without write");

    mute_read_a: assert property (@(posedge clk_i)
        disable iff (srst_i)
        (rd_setup && hit(idx, amp_regs_pkg::IDX_SOFT_MUTE))
        |=> prdata_o == {29'h0, $past(mute_q)})
        else $error("soft mute read wrong");

    mute_reset_a: assert property (@(posedge clk_i)
        $fell(srst_i) |-> soft_mute_o == 3'b000)
        else $error("soft mute default wrong");

endmodule

// *** sim/amp_status_control_regs_bench.sv ***
// Self-checking bench of the amplifier register bank over APB.
// Assumes zero-wait slave and byte address of four times the index.
`timescale 1ns/1ps
module amp_status_control_regs_bench;
    logic        clk_i, srst_i, psel_i, penable_i, pwrite_i, err;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, rd;
    logic        pready_o, pslverr_o, irq_o, dc_o, hu_o, sd_o, mz_o, oe_o;
    logic [1:0]  de_o;
    logic [3:0]  fmt_o;
    logic [2:0]  sm_o;
    logic [6:0]  ev;
    int          mismatches, checks;

    event_source src (.clk_i, .ev_o(ev));
    amp_status_control_regs dut (
        .clk_i, .srst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
        .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .irq_o,
        .mclk_err_i(ev[6]), .pll_err_i(ev[5]), .sclk_err_i(ev[4]),
        .lrclk_err_i(ev[3]), .frame_slip_i(ev[2]), .clip_i(ev[1]),
        .fault_i(ev[0]), .dc_block_en_o(dc_o), .hard_unmute_o(hu_o),
        .deemph_sel_o(de_o), .serial_fmt_o(fmt_o), .shutdown_o(sd_o),
        .midz_ramp_en_o(mz_o), .fault_pin_oe_n_o(oe_o),
        .soft_mute_o(sm_o));

    initial begin
        clk_i = 0;
        forever #2 clk_i = ~clk_i;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] idx,
                       input logic [31:0] wd);
        @(posedge clk_i);
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= wr;
        paddr_i   <= {2'b00, idx, 2'b00};
        pwdata_i  <= wd;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        rd  = prdata_o;
        err = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
        #1;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d);
    endtask

    task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        check(rd, exp);
        check(32'(err), 32'h0);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        #100000;
        mismatches++;
        summarize();
    end

    initial begin
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
        mismatches = 0;
        checks     = 0;
        srst_i     = 1'b1;
        repeat (10) @(posedge clk_i);
        srst_i <= 1'b0;
        rdchk(amp_regs_pkg::IDX_IDENT, 32'h0);
        rdchk(amp_regs_pkg::IDX_ERR, 32'h0);
        rdchk(amp_regs_pkg::IDX_SYS_ONE, 32'hA0);
        rdchk(amp_regs_pkg::IDX_SER_FMT, 32'h05);
        rdchk(amp_regs_pkg::IDX_SYS_TWO, 32'h40);
        rdchk(amp_regs_pkg::IDX_SOFT_MUTE, 32'h0);
        check(32'({dc_o, hu_o, sd_o, oe_o, de_o}), 32'h3C);
        wr(amp_regs_pkg::IDX_IDENT, 32'hFF);
        rdchk(amp_regs_pkg::IDX_IDENT, 32'h0);
        $display("test reset values done");
        for (int b = 0; b < 7; b++) begin
            src.fire(7'(1 << b));
            rdchk(amp_regs_pkg::IDX_ERR, 32'(2 << b));
            wr(amp_regs_pkg::IDX_IRQ_CLR, 32'hFF);
            rdchk(amp_regs_pkg::IDX_ERR, 32'h0);
        end
        src.fire(7'h7F);
        repeat (5) @(posedge clk_i);
        rdchk(amp_regs_pkg::IDX_ERR, 32'hFE);
        wr(amp_regs_pkg::IDX_ERR, 32'hFE);
        rdchk(amp_regs_pkg::IDX_ERR, 32'hFE);
        wr(amp_regs_pkg::IDX_ERR, 32'h0);
        rdchk(amp_regs_pkg::IDX_ERR, 32'h0);
        wr(amp_regs_pkg::IDX_IRQ_EN, 32'hFE);
        rdchk(amp_regs_pkg::IDX_IRQ_EN, 32'hFE);
        src.fire(7'h01);
        check(32'(irq_o), 32'h1);
        wr(amp_regs_pkg::IDX_IRQ_EN, 32'h0);
        check(32'(irq_o), 32'h0);
        wr(amp_regs_pkg::IDX_IRQ_EN, 32'hFE);
        check(32'(irq_o), 32'h1);
        wr(amp_regs_pkg::IDX_IRQ_CLR, 32'h02);
        check(32'(irq_o), 32'h0);
        rdchk(amp_regs_pkg::IDX_ERR, 32'h0);
        $display("test error status done");
        wr(amp_regs_pkg::IDX_SYS_ONE, 32'hFF);
        rdchk(amp_regs_pkg::IDX_SYS_ONE, 32'hA3);
        for (int d = 0; d < 4; d++) begin
            wr(amp_regs_pkg::IDX_SYS_ONE, 32'(d));
            check(32'({dc_o, hu_o, de_o}), 32'(d));
        end
        for (int f = 0; f < 16; f++) begin
            wr(amp_regs_pkg::IDX_SER_FMT, 32'(f));
            rdchk(amp_regs_pkg::IDX_SER_FMT, 32'(f));
            check(32'(fmt_o), 32'(f));
        end
        wr(amp_regs_pkg::IDX_SYS_TWO, 32'hFF);
        rdchk(amp_regs_pkg::IDX_SYS_TWO, 32'hC2);
        check(32'({mz_o, sd_o, oe_o}), 32'h6);
        wr(amp_regs_pkg::IDX_SYS_TWO, 32'h0);
        check(32'({mz_o, sd_o, oe_o}), 32'h1);
        for (int m = 0; m < 8; m++) begin
            wr(amp_regs_pkg::IDX_SOFT_MUTE, 32'(m) | 32'hF8);
            check(32'(sm_o), 32'(m));
        end
        rdchk(amp_regs_pkg::IDX_SOFT_MUTE, 32'h07);
        apb(1'b0, 8'h09, 32'h0);
        check(32'(err), 32'h1);
        check(rd, 32'h0);
        $display("test control registers done");
        summarize();
    end
endmodule

// *** sim/event_source.sv ***
// Stand-in for the serial audio source and power stage event lines.
// Assumes the bank samples the events on the rising edge of clk_i.
`timescale 1ns/1ps
module event_source (
    // Clock
    input  wire logic       clk_i,
    // Events, master clock error first, fault last
    output logic      [6:0] ev_o
);
    initial ev_o = '0;
    // One-cycle burst of the selected events
    task automatic fire(input logic [6:0] m);
        @(posedge clk_i);
        ev_o <= m;
        @(posedge clk_i);
        ev_o <= '0;
        #1;
    endtask
endmodule
